// ==== phs_defines.vh ====
// Constants for the payload header suppression engine
`ifndef PHS_DEFINES_VH
`define PHS_DEFINES_VH
`define PHS_A_CTRL 6'h00
`define PHS_A_SEL 6'h04
`define PHS_A_ACTION 6'h08
`define PHS_A_SIZE 6'h0C
`define PHS_A_INDEX 6'h10
`define PHS_A_FPTR 6'h14
`define PHS_A_FDATA 6'h18
`define PHS_A_MASK 6'h1C
`define PHS_A_VERIFY 6'h20
`define PHS_A_DIR 6'h24
`define PHS_A_ERR 6'h28
`define PHS_A_CNT 6'h2C
`define PHS_A_ELEN 6'h30
`define PHS_CTRL_RST 2'h0
`define PHS_ACT_ADD 2'h0
`define PHS_ACT_SET 2'h1
`define PHS_ACT_DEL 2'h2
`define PHS_ACT_ALL 2'h3
`define PHS_SUB_ACT 8'h05
`define PHS_SUB_FIELD 8'h07
`define PHS_SUB_INDEX 8'h08
`define PHS_SUB_MASK 8'h09
`define PHS_SUB_SIZE 8'h0A
`define PHS_SUB_VERIFY 8'h0B
`define PHS_CC_RANGE 8'h02
`define PHS_CC_REQ 8'h08
`define PHS_CC_NOTFOUND 8'h10
`define PHS_CC_EXISTS 8'h11
`define PHS_CC_DUP 8'h12
`define PHS_CC_CONTEXT 8'h17
`define PHS_ERR_LEN 8'h08
`define PHS_DS_SKIP 9'h00C
`endif

// ==== phs_engine.v ====
// Payload header suppression engine: rule cache, sender and receiver
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "phs_defines.vh"
module phs_engine #(
  parameter EW = 2,
  parameter [7:0] MAXF = 8'hFF
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Register port
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Sender input, bytes after the MAC header checksum
  input wire tx_in_valid,
  input wire [7:0] tx_in_data,
  input wire tx_in_last,
  input wire [EW-1:0] tx_in_rule,
  output reg tx_in_ready,
  // Sender output
  output reg tx_out_valid,
  output reg [7:0] tx_out_data,
  output reg tx_out_last,
  output reg [7:0] tx_out_index,
  input wire tx_out_ready,
  // Receiver input
  input wire rx_in_valid,
  input wire [7:0] rx_in_data,
  input wire rx_in_last,
  input wire [7:0] rx_in_index,
  output reg rx_in_ready,
  // Receiver output
  output reg rx_out_valid,
  output reg [7:0] rx_out_data,
  output reg rx_out_last,
  input wire rx_out_ready
);
  localparam NE = 1 << EW;
  localparam BUFD = 268;
  localparam T_IDLE = 2'd0, T_COL = 2'd1, T_EMIT = 2'd2, T_PASS = 2'd3;
  localparam R_IDLE = 2'd0, R_REB = 2'd1, R_PASS = 2'd2;
  integer i, j, k;
  // Rule cache
  reg [NE-1:0] use_q, szk_q, fdk_q, mkg_q, vsk_q, dir_q;
  reg [7:0] size_q [0:NE-1];
  reg [7:0] idx_q [0:NE-1];
  reg [7:0] field_mem [0:NE*256-1];
  reg [7:0] mask_mem [0:NE*32-1];
  reg [1:0] ctrl_q;
  reg [EW-1:0] sel_q;
  reg [7:0] fptr_q;
  reg [4:0] mptr_q;
  reg err_v_q;
  reg [7:0] err_par_q, err_code_q;
  reg [15:0] sup_cnt_q, vfail_cnt_q;
  wire role = ctrl_q[0];
  wire enable = ctrl_q[1];
  wire u = use_q[sel_q];
  wire fd = use_q[sel_q] & szk_q[sel_q] & fdk_q[sel_q];
  wire [7:0] wb = reg_wdata[7:0];
  reg dup;
  reg [7:0] w_par, w_code;
  always @* begin
    dup = 1'b0;
    for (j = 0; j < NE; j = j + 1) begin
      if (j != sel_q && use_q[j] && dir_q[j] == dir_q[sel_q] && idx_q[j] == wb)
        dup = 1'b1;
    end
  end
  // Refusal decode; a zero code means the write is accepted
  always @* begin
    w_par = 8'h00;
    w_code = 8'h00;
    case (reg_addr)
      `PHS_A_ACTION: begin
        w_par = `PHS_SUB_ACT;
        if (reg_wdata[1:0] == `PHS_ACT_ADD && u)
          w_code = `PHS_CC_EXISTS;
        else if ((reg_wdata[1:0] == `PHS_ACT_SET || reg_wdata[1:0] == `PHS_ACT_DEL) && !u)
          w_code = `PHS_CC_NOTFOUND;
      end
      `PHS_A_SIZE, `PHS_A_INDEX, `PHS_A_FDATA, `PHS_A_MASK, `PHS_A_VERIFY,
      `PHS_A_DIR: begin
        case (reg_addr)
          `PHS_A_SIZE: w_par = `PHS_SUB_SIZE;
          `PHS_A_INDEX: w_par = `PHS_SUB_INDEX;
          `PHS_A_FDATA: w_par = `PHS_SUB_FIELD;
          `PHS_A_MASK: w_par = `PHS_SUB_MASK;
          default: w_par = `PHS_SUB_VERIFY;
        endcase
        if (!u)
          w_code = `PHS_CC_NOTFOUND;
        else if (fd)
          w_code = `PHS_CC_CONTEXT;
        else if (reg_addr == `PHS_A_SIZE && wb > MAXF)
          w_code = `PHS_CC_RANGE;
        else if (reg_addr == `PHS_A_INDEX && wb == 8'h00)
          w_code = `PHS_CC_RANGE;
        else if (reg_addr == `PHS_A_INDEX && dup)
          w_code = `PHS_CC_DUP;
        else if ((reg_addr == `PHS_A_FDATA || reg_addr == `PHS_A_MASK) && !szk_q[sel_q])
          w_code = `PHS_CC_REQ;
        else if (reg_addr == `PHS_A_FDATA && fptr_q >= size_q[sel_q])
          w_code = `PHS_CC_RANGE;
        else if (reg_addr == `PHS_A_MASK && {mptr_q, 3'h0} >= size_q[sel_q])
          w_code = `PHS_CC_RANGE;
      end
      // vendor blocks never reach this port
      default: ;
    endcase
  end
  wire w_err = reg_wr & (w_code != 8'h00);
  wire w_ok = reg_wr & (w_code == 8'h00);
  // Register writes and the error set
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `PHS_CTRL_RST;
      sel_q <= {EW{1'b0}};
      fptr_q <= 8'h00;
      mptr_q <= 5'h00;
      err_v_q <= 1'b0;
      err_par_q <= 8'h00;
      err_code_q <= 8'h00;
      use_q <= {NE{1'b0}};
      szk_q <= {NE{1'b0}};
      fdk_q <= {NE{1'b0}};
      mkg_q <= {NE{1'b0}};
      vsk_q <= {NE{1'b0}};
      dir_q <= {NE{1'b0}};
      for (i = 0; i < NE; i = i + 1) begin
        size_q[i] <= 8'h00;
        idx_q[i] <= 8'h00;
      end
    end else begin
      if (w_err) begin
        err_v_q <= 1'b1;
        err_par_q <= w_par;
        err_code_q <= w_code;
      end else if (reg_wr && reg_addr == `PHS_A_ERR)
        err_v_q <= 1'b0;
      if (w_ok) begin
        case (reg_addr)
          `PHS_A_CTRL: ctrl_q <= reg_wdata[1:0];
          `PHS_A_SEL: sel_q <= reg_wdata[EW-1:0];
          `PHS_A_FPTR: begin
            fptr_q <= 8'h00;
            mptr_q <= 5'h00;
          end
          `PHS_A_ACTION: begin
            case (reg_wdata[1:0])
              `PHS_ACT_ADD: begin
                use_q[sel_q] <= 1'b1;
                szk_q[sel_q] <= 1'b0;
                fdk_q[sel_q] <= 1'b0;
                mkg_q[sel_q] <= 1'b0;
                vsk_q[sel_q] <= 1'b0;
                idx_q[sel_q] <= 8'h00;
                fptr_q <= 8'h00;
                mptr_q <= 5'h00;
              end
              // A deleted rule clears its in-use, size, field and mask flags; its verify and direction bits stay
              `PHS_ACT_DEL: begin
                use_q[sel_q] <= 1'b0;
                szk_q[sel_q] <= 1'b0;
                fdk_q[sel_q] <= 1'b0;
                mkg_q[sel_q] <= 1'b0;
              end
              `PHS_ACT_ALL: begin
                use_q <= {NE{1'b0}};
                szk_q <= {NE{1'b0}};
                fdk_q <= {NE{1'b0}};
                mkg_q <= {NE{1'b0}};
              end
              default: ;
            endcase
          end
          `PHS_A_SIZE: begin
            size_q[sel_q] <= wb;
            szk_q[sel_q] <= 1'b1;
            fdk_q[sel_q] <= (wb == 8'h00);
            fptr_q <= 8'h00;
            mptr_q <= 5'h00;
          end
          `PHS_A_INDEX: idx_q[sel_q] <= wb;
          `PHS_A_FDATA: begin
            fptr_q <= fptr_q + 8'h01;
            if (fptr_q + 8'h01 == size_q[sel_q])
              fdk_q[sel_q] <= 1'b1;
          end
          `PHS_A_MASK: begin
            mptr_q <= mptr_q + 5'h01;
            mkg_q[sel_q] <= 1'b1;
          end
          `PHS_A_VERIFY: vsk_q[sel_q] <= reg_wdata[0];
          `PHS_A_DIR: dir_q[sel_q] <= reg_wdata[0];
          default: ;
        endcase
      end
    end
  end
  always @(posedge mclk) begin
    if (w_ok && reg_addr == `PHS_A_FDATA)
      field_mem[{sel_q, fptr_q}] <= wb;
    if (w_ok && reg_addr == `PHS_A_MASK)
      mask_mem[{sel_q, mptr_q}] <= wb;
  end
  // Read port, one cycle late
  always @(posedge mclk or posedge rst) begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `PHS_A_CTRL: reg_rdata <= {30'h0, ctrl_q};
        `PHS_A_SEL: reg_rdata <= {{(32-EW){1'b0}}, sel_q};
        `PHS_A_ACTION: reg_rdata <= {26'h0, dir_q[sel_q], vsk_q[sel_q], mkg_q[sel_q],
                                     fdk_q[sel_q], szk_q[sel_q], u};
        `PHS_A_SIZE: reg_rdata <= {24'h0, size_q[sel_q]};
        `PHS_A_INDEX: reg_rdata <= {24'h0, idx_q[sel_q]};
        `PHS_A_FPTR: reg_rdata <= {19'h0, mptr_q, fptr_q};
        `PHS_A_ERR: reg_rdata <= {15'h0, err_v_q, err_code_q, err_par_q};
        `PHS_A_CNT: reg_rdata <= {vfail_cnt_q, sup_cnt_q};
        `PHS_A_ELEN: reg_rdata <= {24'h0, `PHS_ERR_LEN};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
  // Sender
  reg [1:0] t_st_q;
  reg [EW-1:0] t_e_q;
  reg [8:0] t_off_q, t_tot_q, t_cnt_q, t_n_q;
  reg t_mis_q, t_last_q, t_sup_q;
  reg [7:0] tbuf [0:BUFD-1];
  wire t_act = enable & fd_at(tx_in_rule) & (dir_q[tx_in_rule] == role);
  wire [8:0] t_pos = t_cnt_q - t_off_q;
  wire t_inf = (t_cnt_q >= t_off_q) && (t_cnt_q < t_tot_q);
  wire t_mb = mkg_q[t_e_q] ? mask_mem[{t_e_q, t_pos[7:3]}][3'h7 - t_pos[2:0]] : 1'b1;
  wire [7:0] t_fb = field_mem[{t_e_q, t_pos[7:0]}];
  wire t_adv = !tx_out_valid | tx_out_ready;
  wire t_done = tx_in_last || (t_cnt_q + 9'h001 == t_tot_q);
  wire t_bad = t_inf & t_mb & !vsk_q[t_e_q] & (tx_in_data != t_fb);
  function fd_at;
    input [EW-1:0] e;
    fd_at = use_q[e] & szk_q[e] & fdk_q[e] & (size_q[e] != 8'h00);
  endfunction
  always @* begin
    case (t_st_q)
      T_COL: tx_in_ready = 1'b1;
      T_PASS: tx_in_ready = t_adv;
      default: tx_in_ready = 1'b0;
    endcase
  end
  always @(posedge mclk) begin
    if (t_st_q == T_COL && tx_in_valid)
      tbuf[t_cnt_q] <= tx_in_data;
  end
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      t_st_q <= T_IDLE;
      t_e_q <= {EW{1'b0}};
      t_off_q <= 9'h000;
      t_tot_q <= 9'h000;
      t_cnt_q <= 9'h000;
      t_n_q <= 9'h000;
      t_mis_q <= 1'b0;
      t_last_q <= 1'b0;
      t_sup_q <= 1'b0;
      tx_out_valid <= 1'b0;
      tx_out_data <= 8'h00;
      tx_out_last <= 1'b0;
      tx_out_index <= 8'h00;
      sup_cnt_q <= 16'h0000;
      vfail_cnt_q <= 16'h0000;
    end else begin
      if (tx_out_ready)
        tx_out_valid <= 1'b0;
      case (t_st_q)
        T_IDLE: if (tx_in_valid) begin
          t_e_q <= tx_in_rule;
          t_cnt_q <= 9'h000;
          t_mis_q <= 1'b0;
          t_off_q <= role ? `PHS_DS_SKIP : 9'h000;
          t_tot_q <= (role ? `PHS_DS_SKIP : 9'h000) + {1'b0, size_q[tx_in_rule]};
          if (t_act)
            t_st_q <= T_COL;
          else begin
            tx_out_index <= 8'h00;
            t_st_q <= T_PASS;
          end
        end
        // The whole header is held so the index is known before byte one
        T_COL: if (tx_in_valid) begin
          t_cnt_q <= t_cnt_q + 9'h001;
          if (t_done) begin
            t_n_q <= t_cnt_q + 9'h001;
            t_cnt_q <= 9'h000;
            t_last_q <= tx_in_last;
            t_sup_q <= !(t_mis_q | t_bad) & !tx_in_last & (t_cnt_q + 9'h001 == t_tot_q);
            if (!(t_mis_q | t_bad) && !tx_in_last && t_cnt_q + 9'h001 == t_tot_q) begin
              tx_out_index <= idx_q[t_e_q];
              sup_cnt_q <= sup_cnt_q + 16'h0001;
            end else
              tx_out_index <= 8'h00;
            if (t_mis_q | t_bad)
              vfail_cnt_q <= vfail_cnt_q + 16'h0001;
            t_st_q <= T_EMIT;
          end else if (t_bad)
            t_mis_q <= 1'b1;
        end
        T_EMIT: begin
          if (t_sup_q && t_inf && t_mb)
            t_cnt_q <= t_cnt_q + 9'h001;
          else if (t_adv) begin
            tx_out_valid <= 1'b1;
            tx_out_data <= tbuf[t_cnt_q];
            tx_out_last <= t_last_q && (t_cnt_q + 9'h001 == t_n_q);
            t_cnt_q <= t_cnt_q + 9'h001;
          end
          if (t_cnt_q + 9'h001 == t_n_q && ((t_sup_q && t_inf && t_mb) || t_adv))
            t_st_q <= t_last_q ? T_IDLE : T_PASS;
        end
        T_PASS: if (tx_in_valid && t_adv) begin
          tx_out_valid <= 1'b1;
          tx_out_data <= tx_in_data;
          tx_out_last <= tx_in_last;
          if (tx_in_last)
            t_st_q <= T_IDLE;
        end
        default: t_st_q <= T_IDLE;
      endcase
    end
  end
  // Receiver
  reg [1:0] r_st_q;
  reg [EW-1:0] r_e_q;
  reg [8:0] r_off_q, r_tot_q, r_cnt_q;
  reg hit;
  reg [EW-1:0] hit_e;
  always @* begin
    hit = 1'b0;
    hit_e = {EW{1'b0}};
    for (k = 0; k < NE; k = k + 1) begin
      if (fd_at(k[EW-1:0]) && dir_q[k] != role && idx_q[k] == rx_in_index &&
          rx_in_index != 8'h00 && enable) begin
        hit = 1'b1;
        hit_e = k[EW-1:0];
      end
    end
  end
  wire [8:0] r_pos = r_cnt_q - r_off_q;
  wire r_inf = (r_cnt_q >= r_off_q) && (r_cnt_q < r_tot_q);
  wire r_mb = mkg_q[r_e_q] ? mask_mem[{r_e_q, r_pos[7:3]}][3'h7 - r_pos[2:0]] : 1'b1;
  wire r_gen = r_inf & r_mb;
  wire r_adv = !rx_out_valid | rx_out_ready;
  always @* begin
    case (r_st_q)
      R_REB: rx_in_ready = r_adv & !r_gen;
      R_PASS: rx_in_ready = r_adv;
      default: rx_in_ready = 1'b0;
    endcase
  end
  // A packet cut short inside the field drops the cached bytes left over
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_st_q <= R_IDLE;
      r_e_q <= {EW{1'b0}};
      r_off_q <= 9'h000;
      r_tot_q <= 9'h000;
      r_cnt_q <= 9'h000;
      rx_out_valid <= 1'b0;
      rx_out_data <= 8'h00;
      rx_out_last <= 1'b0;
    end else begin
      if (rx_out_ready)
        rx_out_valid <= 1'b0;
      case (r_st_q)
        R_IDLE: if (rx_in_valid) begin
          r_e_q <= hit_e;
          r_cnt_q <= 9'h000;
          r_off_q <= role ? 9'h000 : `PHS_DS_SKIP;
          r_tot_q <= (role ? 9'h000 : `PHS_DS_SKIP) + {1'b0, size_q[hit_e]};
          r_st_q <= hit ? R_REB : R_PASS;
        end
        R_REB: if (r_adv && (r_gen || rx_in_valid)) begin
          rx_out_valid <= 1'b1;
          r_cnt_q <= r_cnt_q + 9'h001;
          if (r_gen) begin
            rx_out_data <= field_mem[{r_e_q, r_pos[7:0]}];
            rx_out_last <= 1'b0;
          end else begin
            rx_out_data <= rx_in_data;
            rx_out_last <= rx_in_last;
          end
          if (!r_gen && rx_in_last)
            r_st_q <= R_IDLE;
          else if (r_cnt_q + 9'h001 == r_tot_q)
            r_st_q <= R_PASS;
        end
        R_PASS: if (rx_in_valid && r_adv) begin
          rx_out_valid <= 1'b1;
          rx_out_data <= rx_in_data;
          rx_out_last <= rx_in_last;
          if (rx_in_last)
            r_st_q <= R_IDLE;
        end
        default: r_st_q <= R_IDLE;
      endcase
    end
  end
endmodule // phs_engine
`default_nettype wire

// ==== pse_sink.sv ====
// Stream sink that applies back-pressure to one output stream
`timescale 1ns/1ps
`default_nettype none
module pse_sink #(
  parameter logic [31:0] SEED = 32'h1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Stall control and handshake
  input wire logic stall,
  output logic ready
);
  logic [31:0] lfsr_q;
  // A slow sink drops ready on a pseudo-random pattern, never for long
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lfsr_q <= SEED;
      ready <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      ready <= !stall || lfsr_q[3];
    end
  end
endmodule // pse_sink
`default_nettype wire

// ==== pse_asserts.sv ====
// Concurrent checks on the suppression engine ports
`timescale 1ns/1ps
`default_nettype none
`include "phs_defines.vh"
module pse_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sender stream
  input wire logic tx_in_valid,
  input wire logic tx_in_ready,
  input wire logic tx_out_valid,
  input wire logic [7:0] tx_out_data,
  input wire logic tx_out_last,
  input wire logic [7:0] tx_out_index,
  input wire logic tx_out_ready,
  // Receiver stream
  input wire logic rx_in_valid,
  input wire logic rx_in_ready,
  input wire logic rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic rx_out_last,
  input wire logic rx_out_ready
);
  logic en_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Enable is followed from control writes, since no port shows it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (reg_wr && reg_addr == `PHS_A_CTRL) begin
      en_q <= reg_wdata[1];
    end
  end
  sequence s_err_read;
    reg_rd && reg_addr == `PHS_A_ERR ##1 reg_rdata[16];
  endsequence
  sequence s_tx_stall;
    tx_out_valid && !tx_out_ready;
  endsequence
  sequence s_rx_stall;
    rx_out_valid && !rx_out_ready;
  endsequence
  a_err_code_nonzero: assert property (s_err_read |-> reg_rdata[15:8] != 8'h00)
    else $error("error code reads zero");
  a_err_subtype_known: assert property (s_err_read |-> reg_rdata[7:0] inside {`PHS_SUB_ACT,
    `PHS_SUB_FIELD, `PHS_SUB_INDEX, `PHS_SUB_MASK, `PHS_SUB_SIZE, `PHS_SUB_VERIFY})
    else $error("errored subtype unknown");
  a_elen_fixed: assert property (reg_rd && reg_addr == `PHS_A_ELEN |=>
    reg_rdata == {24'h0, `PHS_ERR_LEN}) else $error("error length wrong");
  a_tx_out_holds: assert property (s_tx_stall |=> tx_out_valid && $stable(tx_out_data)
    && $stable(tx_out_last) && $stable(tx_out_index)) else $error("sender output moved");
  a_rx_out_holds: assert property (s_rx_stall |=> rx_out_valid && $stable(rx_out_data)
    && $stable(rx_out_last)) else $error("receiver output moved");
  a_tx_index_kept: assert property (tx_out_valid && tx_out_ready && !tx_out_last |=>
    !tx_out_valid || tx_out_index == $past(tx_out_index)) else $error("index changed");
  a_off_no_index: assert property (tx_out_valid && !en_q |-> tx_out_index == 8'h00)
    else $error("index while disabled");
  a_tx_first_wait: assert property ($rose(tx_in_valid) |-> !tx_in_ready)
    else $error("sender took first byte at once");
  a_rx_first_wait: assert property ($rose(rx_in_valid) |-> !rx_in_ready)
    else $error("receiver took first byte at once");
endmodule // pse_asserts
bind phs_engine pse_asserts pse_asserts_i (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
  .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_last(tx_out_last),
  .tx_out_index(tx_out_index), .tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid),
  .rx_in_ready(rx_in_ready), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
  .rx_out_last(rx_out_last), .rx_out_ready(rx_out_ready)
);
`default_nettype wire

// ==== payload_header_suppression_engine_test.sv ====
// Self-checking bench for the suppression engine
`timescale 1ns/1ps
`default_nettype none
`include "phs_defines.vh"
module payload_header_suppression_engine_test;
  logic mclk = 1'b0;
  logic rst;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic tx_in_valid = 1'b0;
  logic rx_in_valid = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic in_last = 1'b0;
  logic [1:0] tx_in_rule = 2'h0;
  logic [7:0] rx_in_index = 8'h00;
  logic tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready;
  logic rx_in_ready, rx_out_valid, rx_out_last, rx_out_ready;
  logic [7:0] tx_out_data, tx_out_index, rx_out_data, got_idx;
  logic stall = 1'b0;
  logic done = 1'b0;
  logic en = 1'b0;
  logic [7:0] pkt[$], got[$], exp_q[$];
  logic [7:0] fld [4][8];
  logic [7:0] msk [4];
  logic [7:0] idx [4];
  logic skp [4];
  logic act [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int sz [4];
  logic [1:0] es [4] = '{2'h0, 2'h0, 2'h3, 2'h3};
  logic [5:0] ea [4] = '{`PHS_A_ACTION, `PHS_A_SIZE, `PHS_A_INDEX, `PHS_A_INDEX};
  logic [7:0] ed [4] = '{8'h00, 8'h03, 8'h00, 8'h05};
  logic [15:0] ec [4] = '{{`PHS_CC_EXISTS, `PHS_SUB_ACT}, {`PHS_CC_CONTEXT, `PHS_SUB_SIZE},
    {`PHS_CC_RANGE, `PHS_SUB_INDEX}, {`PHS_CC_DUP, `PHS_SUB_INDEX}};
  logic [31:0] seed = 32'hA84E;
  int error_cnt = 0;
  int compares = 0;
  int sup_n = 0;
  int vf_n = 0;
  always #5 mclk = ~mclk;
  phs_engine #(.EW(2), .MAXF(8'hFF)) phs_engine_i (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_valid(tx_in_valid), .tx_in_data(in_data),
    .tx_in_last(in_last), .tx_in_rule(tx_in_rule), .tx_in_ready(tx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_last(tx_out_last),
    .tx_out_index(tx_out_index), .tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid),
    .rx_in_data(in_data), .rx_in_last(in_last), .rx_in_index(rx_in_index),
    .rx_in_ready(rx_in_ready), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
    .rx_out_last(rx_out_last), .rx_out_ready(rx_out_ready)
  );
  pse_sink #(.SEED(32'h1357)) pse_sink_tx_i (.mclk(mclk), .rst(rst), .stall(stall),
    .ready(tx_out_ready));
  pse_sink #(.SEED(32'h2468)) pse_sink_rx_i (.mclk(mclk), .rst(rst), .stall(stall),
    .ready(rx_out_ready));
  // Output bytes are gathered as the sink accepts them
  always @(posedge mclk) begin
    if (tx_out_valid && tx_out_ready) begin
      if (got.size() == 0) got_idx = tx_out_index;
      got.push_back(tx_out_data);
      done = done | tx_out_last;
    end
    if (rx_out_valid && rx_out_ready) begin
      got.push_back(rx_out_data);
      done = done | rx_out_last;
    end
  end
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk_reg(nm, e & m, reg_rdata & m);
  endtask
  task automatic cfg(input logic [1:0] s, input logic dv, input int n, input logic [7:0] ix,
                     input logic vs, input logic [7:0] m, input logic hm);
    sz[s] = n;
    idx[s] = ix;
    skp[s] = vs;
    msk[s] = hm ? m : 8'hFF;
    wr(`PHS_A_SEL, s);
    wr(`PHS_A_ACTION, `PHS_ACT_ADD);
    wr(`PHS_A_DIR, dv);
    // Verify left at its default unless skipping
    if (vs) wr(`PHS_A_VERIFY, 1);
    wr(`PHS_A_INDEX, ix);
    if (n >= 0) wr(`PHS_A_SIZE, n);
    if (hm) wr(`PHS_A_MASK, m);
    for (int i = 0; i < n; i++) begin
      fld[s][i] = rnd8();
      wr(`PHS_A_FDATA, fld[s][i]);
    end
    rdc("status", `PHS_A_ACTION, {26'h0, dv, vs, hm, n >= 0, n >= 0, 1'b1});
  endtask
  task automatic send_pkt(input logic rxs, input logic [1:0] r, input logic [7:0] ix);
    logic rdy;
    got = {};
    done = 1'b0;
    foreach (pkt[i]) begin
      tx_in_valid <= !rxs;
      rx_in_valid <= rxs;
      in_data <= pkt[i];
      in_last <= (i == pkt.size() - 1);
      tx_in_rule <= r;
      rx_in_index <= ix;
      do begin
        @(negedge mclk);
        rdy = rxs ? rx_in_ready : tx_in_ready;
        @(posedge mclk);
      end while (rdy !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    rx_in_valid <= 1'b0;
    for (int k = 0; k < 300 && !done; k++) @(posedge mclk);
    @(posedge mclk);
    chk_reg("length", exp_q.size(), got.size());
    foreach (exp_q[i]) chk_byte("stream", exp_q[i], got[i]);
  endtask
  task automatic run_tx(input logic [1:0] r, input int tail, input int bad);
    logic ok;
    logic vfail;
    int n;
    pkt = {};
    exp_q = {};
    vfail = 1'b0;
    n = sz[r] + tail;
    for (int i = 0; i < n; i++) pkt.push_back(i < sz[r] ? fld[r][i] : rnd8());
    if (bad >= 0) pkt[bad] = ~pkt[bad];
    ok = en && act[r] && n > sz[r];
    for (int i = 0; i < sz[r]; i++) vfail |= msk[r][7 - i] && pkt[i] !== fld[r][i];
    if (ok && vfail && !skp[r]) begin
      vf_n++;
      ok = 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      if (!ok || i >= sz[r] || !msk[r][7 - i]) exp_q.push_back(pkt[i]);
    end
    if (ok) sup_n++;
    send_pkt(1'b0, r, 8'h00);
    chk_byte("tx_index", ok ? idx[r] : 8'h00, got_idx);
  endtask
  task automatic run_rx(input logic [7:0] ix, input int n);
    pkt = {};
    for (int i = 0; i < n; i++) pkt.push_back(rnd8());
    exp_q = pkt;
    // Downstream field starts after twelve passed bytes
    if (ix == idx[1]) begin
      exp_q.insert(12, fld[1][1]);
      exp_q.insert(12, fld[1][0]);
    end
    send_pkt(1'b1, 2'h0, ix);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc("ctrl", `PHS_A_CTRL, 32'h0);
    rdc("elen", `PHS_A_ELEN, 32'h8);
    rdc("unmapped", 6'h3C, 32'h0);
    rdc("unused", `PHS_A_ACTION, 32'h0);
    cfg(2'h0, 1'b0, 4, 8'h05, 1'b0, 8'hB0, 1'b1);
    cfg(2'h1, 1'b1, 2, 8'h05, 1'b1, 8'h00, 1'b0);
    cfg(2'h2, 1'b0, 2, 8'h09, 1'b1, 8'h40, 1'b1);
    cfg(2'h3, 1'b0, -1, 8'h07, 1'b0, 8'h00, 1'b0);
    rdc("err_none", `PHS_A_ERR, 32'h0, 32'h10000);
    for (int i = 0; i < 4; i++) begin
      wr(`PHS_A_SEL, es[i]);
      wr(ea[i], ed[i]);
      rdc("err", `PHS_A_ERR, {15'h0, 1'b1, ec[i]});
      wr(`PHS_A_ERR, 32'h0);
      rdc("err_clr", `PHS_A_ERR, 32'h0, 32'h10000);
    end
    en = 1'b1;
    wr(`PHS_A_CTRL, 32'h2);
    run_tx(2'h0, 3, -1);
    run_tx(2'h0, 2, 1);
    run_tx(2'h0, 2, 2);
    run_tx(2'h2, 3, 1);
    run_tx(2'h0, 0, -1);
    run_tx(2'h1, 3, -1);
    run_tx(2'h3, 3, -1);
    wr(`PHS_A_SIZE, 32'h0);
    sz[3] = 0;
    run_tx(2'h3, 3, -1);
    stall <= 1'b1;
    for (int k = 0; k < 4; k++) run_tx(2'h0, 1 + rnd8() % 6, (rnd8() & 1) ? 2 : -1);
    for (int k = 0; k < 3; k++) run_rx(8'h05, 13 + (rnd8() & 7));
    run_rx(8'h09, 16);
    rdc("cnt", `PHS_A_CNT, {vf_n[15:0], sup_n[15:0]});
    en = 1'b0;
    wr(`PHS_A_CTRL, 32'h0);
    run_tx(2'h0, 2, -1);
    wr(`PHS_A_SEL, 32'h0);
    wr(`PHS_A_ACTION, `PHS_ACT_ALL);
    rdc("deleted", `PHS_A_ACTION, 32'h0);
    wr(`PHS_A_ACTION, `PHS_ACT_DEL);
    rdc("err", `PHS_A_ERR, {15'h0, 1'b1, `PHS_CC_NOTFOUND, `PHS_SUB_ACT});
    complete_run();
  end
endmodule // payload_header_suppression_engine_test
`default_nettype wire
